// [rtl/sfb_map.svh]
// register offsets, field positions, reset values and timing factors of the sfr bank
// assumes an 8-bit special function register address space
`ifndef SFB_MAP_SVH
`define SFB_MAP_SVH
`define SFB_ADDR_SUM2    8'hE4
`define SFB_ADDR_SUM3    8'hE5
`define SFB_ADDR_TRIM    8'hE6
`define SFB_ADDR_LVD     8'hE7
`define SFB_ADDR_EIE     8'hE8
`define SFB_ADDR_PCLO    8'hE9
`define SFB_ADDR_PCHI    8'hEA
`define SFB_ADDR_HWVER   8'hEB
`define SFB_ADDR_FCTL    8'hEE
`define SFB_ADDR_FTIM    8'hEF
`define SFB_ADDR_AUXB    8'hF0
`define SFB_ADDR_PDN     8'hF1
`define SFB_RST_EIE      8'hE0
`define SFB_RST_FCTL     8'h02
`define SFB_RST_FTIM     8'hA5
`define SFB_RST_PDN      8'h7F
`define SFB_FIX_EIE      8'hE0
`define SFB_FIX_FCTL     8'h02
`define SFB_FIX_PDN      8'h20
`define SFB_MSK_EIE      8'h1F
`define SFB_MSK_FCTL     8'h50
`define SFB_MSK_PDN      8'h5F
`define SFB_PCLO_FIXED   8'h04
`define SFB_EXT_LEVEL    3'h7
`define SFB_WRITE_MULT   5
`endif

// [rtl/sfb_pkg.sv]
// types shared by the sfr bank
// assumes the sfb_map.svh header for numbers
package sfb_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfb_bus_t;

  typedef struct packed {
    logic [2:0] analog_level;
    logic       analog_enable;
    logic       analog_ext_compare;
    logic [2:0] digital_level;
    logic       digital_enable;
    logic       digital_ext_compare;
  } sfb_lvd_t;

  typedef struct packed {
    logic converter_out_powerdown;
    logic modulator_powerdown;
    logic analog_front_powerdown;
    logic watchdog_powerdown;
    logic system_timer_powerdown;
    logic serial_port_powerdown;
  } sfb_pdn_t;

  typedef enum logic [2:0] {
    SFB_IDLE  = 3'b001,
    SFB_WRITE = 3'b010,
    SFB_ERASE = 3'b100
  } sfb_fstate_t;

  typedef struct packed {
    logic [7:0]  sum2;
    logic [7:0]  sum3;
    logic [7:0]  trim;
    logic [7:0]  lvd;
    logic [4:0]  extended_irq_enable;
    logic        pg_erase;
    logic        delay_line;
    logic [7:0]  ftim;
    logic [7:0]  auxb;
    logic [5:0]  pdn;
    logic [7:0]  rdata;
    sfb_fstate_t fstate;
    logic [31:0] fcount;
    logic        busy;
    logic [4:0]  irq_gated;
    logic        trim_neg;
    logic [6:0]  trim_mag;
    sfb_lvd_t    lvd_out;
    sfb_pdn_t    pdn_out;
  } sfb_state_t;
endpackage

// [rtl/sfb_bank.sv]
// special function register bank: summation high bytes, offset trim, supply detect,
// extended irq enables, product codes, flash control and timing, aux accumulator, power down.
// assumes the core bus issues single-cycle rd/wr strobes on clk; rdata valid next cycle.
`timescale 1ns/1ps
`include "sfb_map.svh"
module sfb_bank #(
  parameter logic [7:0] PRODUCT_CODE_HIGH = 8'h5A, // arbitrary value
  parameter logic [4:0] PRODUCT_CODE_LOW  = 5'h03, // arbitrary value
  parameter logic [1:0] FLASH_SIZE_CODE   = 2'h3,
  parameter logic [7:0] HW_VERSION        = 8'h11  // arbitrary value
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire sfb_pkg::sfb_bus_t bus,
  output logic [7:0]            rdata,
  input  wire logic [31:0]      sum_in,
  input  wire logic             sum_bipolar,
  output logic [7:0]            sum2_wdata,
  output logic [7:0]            sum3_wdata,
  output logic                  sum2_wr,
  output logic                  sum3_wr,
  output logic                  trim_neg,
  output logic [6:0]            trim_mag,
  output sfb_pkg::sfb_lvd_t     lvd,
  input  wire logic [4:0]       irq_req,
  output logic [4:0]            irq_gated,
  output logic                  page_erase_select,
  output logic                  delay_line_select,
  input  wire logic             flash_write_start,
  input  wire logic             flash_erase_start,
  input  wire logic [15:0]      millisecond_divider,
  input  wire logic [4:0]       microsecond_divider,
  output logic                  flash_busy,
  output logic [7:0]            aux_accumulator,
  output sfb_pkg::sfb_pdn_t     pdn
);
  sfb_pkg::sfb_state_t s_q;
  sfb_pkg::sfb_state_t s_d;
  logic [7:0] sum2_eff;
  logic [7:0] sum3_eff;

  function automatic logic hit(input sfb_pkg::sfb_bus_t b, input logic [7:0] a);
    hit = b.wr && (b.addr == a);
  endfunction

  // the accumulator holds 24-bit results; in bipolar mode the upper byte follows the sign
  always_comb
  begin
    sum2_eff = sum_in[23:16];
    sum3_eff = sum_bipolar ? {8{sum_in[23]}} : sum_in[31:24];
  end

  always_comb
  begin
    s_d = s_q;
    if (hit(bus, `SFB_ADDR_TRIM))  s_d.trim = bus.wdata;
    if (hit(bus, `SFB_ADDR_LVD))   s_d.lvd = bus.wdata;
    if (hit(bus, `SFB_ADDR_EIE))   s_d.extended_irq_enable = bus.wdata[4:0];
    if (hit(bus, `SFB_ADDR_FCTL))
    begin
      s_d.pg_erase   = bus.wdata[6];
      s_d.delay_line = bus.wdata[4];
    end
    if (hit(bus, `SFB_ADDR_FTIM))  s_d.ftim = bus.wdata;
    if (hit(bus, `SFB_ADDR_AUXB))  s_d.auxb = bus.wdata;
    if (hit(bus, `SFB_ADDR_PDN))   s_d.pdn = {bus.wdata[6], bus.wdata[4:0]};
    // sum bytes are owned by the accumulator; writes are forwarded as strobes
    s_d.sum2 = hit(bus, `SFB_ADDR_SUM2) ? bus.wdata : s_q.sum2;
    s_d.sum3 = hit(bus, `SFB_ADDR_SUM3) ? bus.wdata : s_q.sum3;

    s_d.rdata = 8'h00;
    if (bus.rd)
    begin
      unique case (bus.addr)
        `SFB_ADDR_SUM2:  s_d.rdata = sum2_eff;
        `SFB_ADDR_SUM3:  s_d.rdata = sum3_eff;
        `SFB_ADDR_TRIM:  s_d.rdata = s_q.trim;
        `SFB_ADDR_LVD:   s_d.rdata = s_q.lvd;
        `SFB_ADDR_EIE:   s_d.rdata = `SFB_FIX_EIE | {3'h0, s_q.extended_irq_enable};
        `SFB_ADDR_PCLO:  s_d.rdata = {PRODUCT_CODE_LOW, 1'b1, FLASH_SIZE_CODE};
        `SFB_ADDR_PCHI:  s_d.rdata = PRODUCT_CODE_HIGH;
        `SFB_ADDR_HWVER: s_d.rdata = HW_VERSION;
        `SFB_ADDR_FCTL:  s_d.rdata = `SFB_FIX_FCTL | {1'b0, s_q.pg_erase, 1'b0,
                                     s_q.delay_line, 1'b0, s_q.busy, 2'b00};
        `SFB_ADDR_FTIM:  s_d.rdata = s_q.ftim;
        `SFB_ADDR_AUXB:  s_d.rdata = s_q.auxb;
        `SFB_ADDR_PDN:   s_d.rdata = `SFB_FIX_PDN | {1'b0, s_q.pdn[5], 1'b0, s_q.pdn[4:0]};
        default:         s_d.rdata = 8'h00;
      endcase
    end

    // flash timing: counts run down to zero, busy reads while nonzero
    unique case (s_q.fstate)
      sfb_pkg::SFB_IDLE:
      begin
        if (flash_erase_start)
        begin
          s_d.fstate = sfb_pkg::SFB_ERASE;
          s_d.fcount = 32'({28'h0, s_q.ftim[7:4]} + 32'h1)
                     * 32'({16'h0, millisecond_divider} + 32'h1);
        end
        else if (flash_write_start)
        begin
          s_d.fstate = sfb_pkg::SFB_WRITE;
          s_d.fcount = 32'({28'h0, s_q.ftim[3:0]} + 32'h1)
                     * 32'({27'h0, microsecond_divider} + 32'h1)
                     * 32'(`SFB_WRITE_MULT);
        end
      end
      sfb_pkg::SFB_WRITE, sfb_pkg::SFB_ERASE:
      begin
        s_d.fcount = s_q.fcount - 32'h1;
        if (s_q.fcount == 32'h1)
          s_d.fstate = sfb_pkg::SFB_IDLE;
      end
      default: s_d.fstate = sfb_pkg::SFB_IDLE;
    endcase
    s_d.busy = (s_d.fstate != sfb_pkg::SFB_IDLE);

    // registered views of the control fields
    s_d.irq_gated = irq_req & s_q.extended_irq_enable;
    s_d.trim_neg  = s_q.trim[7];
    s_d.trim_mag  = s_q.trim[6:0];
    s_d.lvd_out.analog_enable       = ~s_q.lvd[7];
    s_d.lvd_out.analog_level        = s_q.lvd[6:4];
    s_d.lvd_out.analog_ext_compare  = (s_q.lvd[6:4] == `SFB_EXT_LEVEL);
    s_d.lvd_out.digital_enable      = ~s_q.lvd[3];
    s_d.lvd_out.digital_level       = s_q.lvd[2:0];
    s_d.lvd_out.digital_ext_compare = (s_q.lvd[2:0] == `SFB_EXT_LEVEL);
    s_d.pdn_out.converter_out_powerdown = s_q.pdn[5];
    s_d.pdn_out.modulator_powerdown     = s_q.pdn[4];
    s_d.pdn_out.analog_front_powerdown  = s_q.pdn[3];
    s_d.pdn_out.watchdog_powerdown      = s_q.pdn[2];
    s_d.pdn_out.system_timer_powerdown  = s_q.pdn[1];
    s_d.pdn_out.serial_port_powerdown   = s_q.pdn[0];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q            <= '0;
      s_q.extended_irq_enable        <= 5'h00;
      s_q.ftim       <= `SFB_RST_FTIM;
      s_q.pdn        <= 6'h3F;
      s_q.fstate     <= sfb_pkg::SFB_IDLE;
      s_q.trim_mag   <= 7'h00;
      s_q.pdn_out    <= 6'h3F;
      s_q.lvd_out    <= 10'h042;
    end
    else
      s_q <= s_d;
  end

  // sum write strobes: registered one cycle after the bus write
  logic sum2_wr_q;
  logic sum3_wr_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sum2_wr_q <= 1'b0;
      sum3_wr_q <= 1'b0;
    end
    else
    begin
      sum2_wr_q <= hit(bus, `SFB_ADDR_SUM2);
      sum3_wr_q <= hit(bus, `SFB_ADDR_SUM3);
    end
  end

  assign rdata             = s_q.rdata;
  assign sum2_wdata        = s_q.sum2;
  assign sum3_wdata        = s_q.sum3;
  assign sum2_wr           = sum2_wr_q;
  assign sum3_wr           = sum3_wr_q;
  assign trim_neg          = s_q.trim_neg;
  assign trim_mag          = s_q.trim_mag;
  assign lvd               = s_q.lvd_out;
  assign irq_gated         = s_q.irq_gated;
  assign page_erase_select = s_q.pg_erase;
  assign delay_line_select = s_q.delay_line;
  assign flash_busy        = s_q.busy;
  assign aux_accumulator   = s_q.auxb;
  assign pdn               = s_q.pdn_out;

  property p_busy_start;
    @(posedge clk) disable iff (!reset_n)
    (s_q.fstate == sfb_pkg::SFB_IDLE) && (flash_erase_start || flash_write_start)
      |=> flash_busy;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not set on start");

  property p_write_len;
    @(posedge clk) disable iff (!reset_n)
    (s_q.fstate == sfb_pkg::SFB_IDLE) && flash_write_start && !flash_erase_start
      && s_q.ftim[3:0] == 4'h0 && microsecond_divider == 5'h00
      |=> flash_busy [*5] ##1 !flash_busy;
  endproperty
  a_write_len: assert property (p_write_len) else $error("write time wrong");

  property p_erase_len;
    @(posedge clk) disable iff (!reset_n)
    (s_q.fstate == sfb_pkg::SFB_IDLE) && flash_erase_start
      && s_q.ftim[7:4] == 4'h1 && millisecond_divider == 16'h0001
      |=> flash_busy [*4] ##1 !flash_busy;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase time wrong");

  property p_irq_gate;
    @(posedge clk) disable iff (!reset_n)
    ##1 irq_gated == ($past(irq_req) & $past(s_q.extended_irq_enable));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq gating wrong");

  property p_pclo;
    @(posedge clk) disable iff (!reset_n)
    bus.rd && bus.addr == `SFB_ADDR_PCLO |=> rdata[2] && rdata[1:0] == FLASH_SIZE_CODE;
  endproperty
  a_pclo: assert property (p_pclo) else $error("product code low wrong");

  property p_pchi;
    @(posedge clk) disable iff (!reset_n)
    bus.rd && bus.addr == `SFB_ADDR_PCHI |=> rdata == PRODUCT_CODE_HIGH;
  endproperty
  a_pchi: assert property (p_pchi) else $error("product code high wrong");

  property p_fix_bits;
    @(posedge clk) disable iff (!reset_n)
    bus.rd && bus.addr == `SFB_ADDR_PDN |=> rdata[7] == 1'b0 && rdata[5];
  endproperty
  a_fix_bits: assert property (p_fix_bits) else $error("fixed bits wrong");

  property p_lvd_en;
    @(posedge clk) disable iff (!reset_n)
    hit(bus, `SFB_ADDR_LVD) |=> ##1 lvd.analog_enable == !$past(bus.wdata[7], 2)
      && lvd.digital_enable == !$past(bus.wdata[3], 2);
  endproperty
  a_lvd_en: assert property (p_lvd_en) else $error("detect enable wrong");

  property p_trim;
    @(posedge clk) disable iff (!reset_n)
    hit(bus, `SFB_ADDR_TRIM) |=> ##1 trim_neg == $past(bus.wdata[7], 2)
      && trim_mag == $past(bus.wdata[6:0], 2);
  endproperty
  a_trim: assert property (p_trim) else $error("trim split wrong");

  // request shapes shared by the checks below
  sequence s_rd_at(logic [7:0] a);
    bus.rd && bus.addr == a;
  endsequence
  sequence s_wr_at(logic [7:0] a);
    hit(bus, a);
  endsequence
  sequence s_flash_idle;
    s_q.fstate == sfb_pkg::SFB_IDLE;
  endsequence

  property p_sum2_read;
    @(posedge clk) disable iff (!reset_n)
    s_rd_at(`SFB_ADDR_SUM2) |=> rdata == $past(sum_in[23:16]);
  endproperty
  a_sum2_read: assert property (p_sum2_read) else $error("sum byte two read wrong");

  property p_sum3_read;
    @(posedge clk) disable iff (!reset_n)
    s_rd_at(`SFB_ADDR_SUM3) |=> rdata == ($past(sum_bipolar) ? {8{$past(sum_in[23])}}
                                          : $past(sum_in[31:24]));
  endproperty
  a_sum3_read: assert property (p_sum3_read) else $error("sum byte three read wrong");

  property p_sum2_strobe;
    @(posedge clk) disable iff (!reset_n)
    s_wr_at(`SFB_ADDR_SUM2) |=> sum2_wr && sum2_wdata == $past(bus.wdata);
  endproperty
  a_sum2_strobe: assert property (p_sum2_strobe) else $error("sum two strobe wrong");

  property p_sum3_strobe;
    @(posedge clk) disable iff (!reset_n)
    s_wr_at(`SFB_ADDR_SUM3) |=> sum3_wr && sum3_wdata == $past(bus.wdata);
  endproperty
  a_sum3_strobe: assert property (p_sum3_strobe) else $error("sum three strobe wrong");

  property p_eie_fixed;
    @(posedge clk) disable iff (!reset_n)
    s_rd_at(`SFB_ADDR_EIE) |=> rdata[7:5] == 3'h7;
  endproperty
  a_eie_fixed: assert property (p_eie_fixed) else $error("irq enable fixed bits wrong");

  property p_fctl_fixed;
    @(posedge clk) disable iff (!reset_n)
    s_rd_at(`SFB_ADDR_FCTL) |=> rdata[1] && !rdata[0] && !rdata[3]
      && !rdata[5] && !rdata[7];
  endproperty
  a_fctl_fixed: assert property (p_fctl_fixed) else $error("flash fixed bits wrong");

  property p_fctl_busy;
    @(posedge clk) disable iff (!reset_n)
    s_rd_at(`SFB_ADDR_FCTL) |=> rdata[2] == $past(flash_busy);
  endproperty
  a_fctl_busy: assert property (p_fctl_busy) else $error("busy bit read wrong");

  property p_pg_erase;
    @(posedge clk) disable iff (!reset_n)
    s_wr_at(`SFB_ADDR_FCTL) |=> page_erase_select == $past(bus.wdata[6]);
  endproperty
  a_pg_erase: assert property (p_pg_erase) else $error("page erase select wrong");

  property p_delay_line;
    @(posedge clk) disable iff (!reset_n)
    s_wr_at(`SFB_ADDR_FCTL) |=> delay_line_select == $past(bus.wdata[4]);
  endproperty
  a_delay_line: assert property (p_delay_line) else $error("delay line select wrong");

  property p_aux;
    @(posedge clk) disable iff (!reset_n)
    s_wr_at(`SFB_ADDR_AUXB) |=> aux_accumulator == $past(bus.wdata);
  endproperty
  a_aux: assert property (p_aux) else $error("aux accumulator wrong");

  property p_pdn_map;
    @(posedge clk) disable iff (!reset_n)
    s_wr_at(`SFB_ADDR_PDN) |=> ##1 pdn == {$past(bus.wdata[6], 2),
                                            $past(bus.wdata[4:0], 2)};
  endproperty
  a_pdn_map: assert property (p_pdn_map) else $error("power down map wrong");

  property p_lvd_level;
    @(posedge clk) disable iff (!reset_n)
    s_wr_at(`SFB_ADDR_LVD) |=> ##1
      lvd.analog_ext_compare == ($past(bus.wdata[6:4], 2) == `SFB_EXT_LEVEL)
      && lvd.digital_ext_compare == ($past(bus.wdata[2:0], 2) == `SFB_EXT_LEVEL);
  endproperty
  a_lvd_level: assert property (p_lvd_level) else $error("detect level compare wrong");

  property p_idle_quiet;
    @(posedge clk) disable iff (!reset_n)
    s_flash_idle ##0 (!flash_erase_start && !flash_write_start) |=> !flash_busy;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("busy without start");

  property p_erase_wins;
    @(posedge clk) disable iff (!reset_n)
    s_flash_idle ##0 flash_erase_start |=> s_q.fstate == sfb_pkg::SFB_ERASE;
  endproperty
  a_erase_wins: assert property (p_erase_wins) else $error("erase not taken");

  property p_start_ignored;
    @(posedge clk) disable iff (!reset_n)
    flash_busy && s_q.fcount > 32'h1 && flash_write_start |=> flash_busy;
  endproperty
  a_start_ignored: assert property (p_start_ignored) else $error("busy cut short");
endmodule

// [tb/sfb_core_model.sv]
// core-side model of the sfr bus: one read or write strobe held for one clock
// assumes the bank takes the request on the rising clk edge that follows the drive edge
`timescale 1ns/1ps
module sfb_core_model (
  input  wire logic         clk,
  output sfb_pkg::sfb_bus_t bus
);
  initial bus = '{wr: 1'b0, rd: 1'b0, addr: 8'hFF, wdata: 8'hFF};

  // software side: trim is only written here with no calibration pending
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    // released lines show the inverse so a stale copy never passes for a request
    bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench of the sfr bank: register table, field views, irq gating, flash timer
// assumes sfb_core_model drives the bus and rdata lands one edge after a read is taken
`timescale 1ns/1ps
`define CHK(nm, ex, sn) \
  begin \
    checks++; \
    if ((sn) !== (ex)) \
    begin \
      failures++; \
      $display("ERROR %s expected %0h seen %0h", nm, ex, sn); \
    end \
  end
module tb_top;
  localparam logic [7:0] PC_HIGH = 8'h3C; // arbitrary value
  localparam logic [4:0] PC_LOW  = 5'h0A; // arbitrary value
  localparam logic [7:0] HW_VER  = 8'h2B; // arbitrary value
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  sfb_pkg::sfb_bus_t bus;
  logic [7:0]        rdata, sum2_wdata, sum3_wdata, aux_accumulator;
  logic              sum2_wr, sum3_wr, trim_neg, page_erase_select, delay_line_select;
  logic [6:0]        trim_mag;
  sfb_pkg::sfb_lvd_t lvd;
  sfb_pkg::sfb_pdn_t pdn;
  logic [4:0]        irq_gated;
  logic              flash_busy;
  logic [31:0]       sum_in = 32'h0;
  logic              sum_bipolar = 1'b0;
  logic [4:0]        irq_req = 5'h0;
  logic              flash_write_start = 1'b0;
  logic              flash_erase_start = 1'b0;
  logic [15:0]       millisecond_divider = 16'h0;
  logic [4:0]        microsecond_divider = 5'h0;
  int                failures = 0;
  int                checks = 0;
  int                cycles = 0;
  logic              rd_seen = 1'b0;
  logic [7:0]        exp_q[$];
  logic [7:0]        exp_rd;
  logic [31:0]       seed = 32'hDEEAF785;
  logic [7:0] ra [10] = '{8'hE6, 8'hE7, 8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEE, 8'hEF, 8'hF0, 8'hF1};
  logic [7:0] rv [10] = '{8'h00, 8'h00, 8'hE0, {PC_LOW, 1'b1, 2'h1}, PC_HIGH, HW_VER,
                          8'h02, 8'hA5, 8'h00, 8'h7F};
  logic [7:0] mk [10] = '{8'hFF, 8'hFF, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h50, 8'hFF, 8'hFF, 8'h5F};
  logic [7:0] fx [10] = '{8'h00, 8'h00, 8'hE0, {PC_LOW, 1'b1, 2'h1}, PC_HIGH, HW_VER,
                          8'h02, 8'h00, 8'h00, 8'h20};

  always #2 clk = ~clk;

  sfb_core_model core_i (.clk(clk), .bus(bus));

  sfb_bank #(.PRODUCT_CODE_HIGH(PC_HIGH), .PRODUCT_CODE_LOW(PC_LOW),
             .FLASH_SIZE_CODE(2'h1), .HW_VERSION(HW_VER)) sfb_bank_i (
    .clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .sum_in(sum_in),
    .sum_bipolar(sum_bipolar), .sum2_wdata(sum2_wdata), .sum3_wdata(sum3_wdata),
    .sum2_wr(sum2_wr), .sum3_wr(sum3_wr), .trim_neg(trim_neg), .trim_mag(trim_mag),
    .lvd(lvd), .irq_req(irq_req), .irq_gated(irq_gated),
    .page_erase_select(page_erase_select), .delay_line_select(delay_line_select),
    .flash_write_start(flash_write_start), .flash_erase_start(flash_erase_start),
    .millisecond_divider(millisecond_divider), .microsecond_divider(microsecond_divider),
    .flash_busy(flash_busy), .aux_accumulator(aux_accumulator), .pdn(pdn));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    core_i.access(1'b1, a, dv);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    exp_q.push_back(ex);
    core_i.access(1'b0, a, 8'h00);
  endtask

  task automatic tally_and_finish;
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // counts busy cycles; a second start in mid-run must not stretch the count
  task automatic run_flash(input logic erase, input int exp_n);
    int n;
    n = 0;
    @(posedge clk);
    flash_erase_start <= erase;
    flash_write_start <= !erase;
    @(posedge clk);
    flash_erase_start <= 1'b0;
    flash_write_start <= 1'b0;
    #1;
    while (flash_busy === 1'b1 && n < 500)
    begin
      n++;
      @(posedge clk);
      flash_write_start <= (n == 3);
      #1;
    end
    `CHK("busy_cycles", exp_n, n)
  endtask

  // the read answer is a one-cycle pulse, so it is compared in the cycle after the take
  always @(posedge clk)
  begin
    if (rd_seen)
    begin
      exp_rd = exp_q.pop_front();
      `CHK("rdata", exp_rd, rdata)
    end
    rd_seen <= bus.rd;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  initial
  begin
    logic [31:0] s;
    logic [7:0]  d;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
    rd(8'hE0, 8'h00);
    rd(8'hF2, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      d = 8'(rnd());
      wr(ra[i], d);
      rd(ra[i], (d & mk[i]) | fx[i]);
    end
    for (int k = 0; k < 2; k++)
    begin
      s = rnd();
      s[23] = 1'b1;
      sum_in <= s;
      sum_bipolar <= k[0];
      rd(8'hE4, s[23:16]);
      rd(8'hE5, k[0] ? 8'hFF : s[31:24]);
      d = 8'(rnd());
      wr(k[0] ? 8'hE5 : 8'hE4, d);
      #1;
      `CHK("sum_wr", {k[0], !k[0]}, {sum3_wr, sum2_wr})
      `CHK("sum_wdata", d, k[0] ? sum3_wdata : sum2_wdata)
      d = {k[0], 7'(rnd())};
      wr(8'hE6, d);
      @(posedge clk);
      #1;
      `CHK("trim", d, {trim_neg, trim_mag})
      wr(8'hEE, k[0] ? 8'h50 : 8'h00);
      #1;
      `CHK("fctl", {k[0], k[0]}, {page_erase_select, delay_line_select})
      d = 8'(rnd());
      wr(8'hF0, d);
      #1;
      `CHK("aux", d, aux_accumulator)
    end
    for (int c = 0; c < 8; c++)
    begin
      d = {c[0], 3'(c), c[1], 3'(7 - c)};
      wr(8'hE7, d);
      @(posedge clk);
      #1;
      `CHK("lvd", {3'(c), !c[0], c == 7, 3'(7 - c), !c[1], c == 0}, lvd)
      d = 8'(rnd());
      wr(8'hF1, d);
      @(posedge clk);
      #1;
      `CHK("pdn", {d[6], d[4], d[3], d[2], d[1], d[0]}, pdn)
      d = 8'(rnd());
      wr(8'hE8, d);
      irq_req <= 5'(rnd());
      @(posedge clk);
      @(posedge clk);
      #1;
      `CHK("irq", irq_req & d[4:0], irq_gated)
    end
    wr(8'hEF, 8'h21);
    microsecond_divider <= 5'h02;
    millisecond_divider <= 16'h0003;
    run_flash(1'b0, 30);
    run_flash(1'b1, 12);
    wr(8'hEF, 8'h20);
    microsecond_divider <= 5'h00;
    run_flash(1'b0, 5);
    wr(8'hEF, 8'h70);
    @(posedge clk);
    flash_erase_start <= 1'b1;
    @(posedge clk);
    flash_erase_start <= 1'b0;
    // page erase and delay line still set from the last flash control write
    rd(8'hEE, 8'h56);
    for (int n = 0; n < 40 && flash_busy !== 1'b0; n++) @(posedge clk);
    rd(8'hEE, 8'h52);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'hEF, 8'hA5);
    rd(8'hF1, 8'h7F);
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule
